// file: core/emr_mac_regs.sv
// emr_mac_regs: register side of the ethernet mac: statistics counters,
// configuration, management and pattern-match registers, test controls.
// assumes a synchronous system-bus register port, one access per cycle.
`timescale 1ns/1ps
// Operation
// [RULE1] Backpressure test bit sends preamble to raise carrier, queued frames still go.
// [RULE2] Forced-pause test bit inhibits transmit as if a non-zero pause arrived.
// [RULE3] Short-quantum test bit makes one pause quantum a single byte time.
// [RULE4] Software changes pattern registers only with receive off or mode zero.
// [RULE5] Pattern checksum and offset feed receive only, never transmit.
// [RULE6] Pattern checksum holds checksum one in 15:8, zero in 7:0; upper reads zero.
// [RULE7] Pattern offset is a sixteen-bit read/write field resetting to zero.
// [RULE8] Every register has clear, set, invert aliases at plus four, eight, twelve.
// [RULE9] Half and word accesses work, byte accesses are ignored entirely.
// [RULE10] Unimplemented bits and bits 31:16 read zero and ignore writes.
// [RULE11] Each statistics counter adds one per frame of its class, resets zero.
module emr_mac_regs
  import emr_pkg::*;
#(
  parameter int PM_MODE_W = 4
) (
  input  wire logic                 clk,             // system clock, 20 MHz
  input  wire logic                 rst,             // async reset, active high
  input  wire logic [emr_pkg::ADDR_W-1:0] reg_addr,  // byte address, low bits
  input  wire logic                 reg_wr,          // write strobe
  input  wire logic                 reg_rd,          // read strobe
  input  wire logic [1:0]           reg_size,        // 0 byte, 1 half, 2 word
  input  wire logic [31:0]          reg_wdata,       // write data
  output logic      [31:0]          reg_rdata,       // read data, registered
  output logic                      reg_rvalid,      // read data valid pulse
  input  wire logic                 ev_tx_good,      // good frame sent
  input  wire logic                 ev_single_col,   // sent after one collision
  input  wire logic                 ev_multi_col,    // sent after several
  input  wire logic                 ev_rx_good,      // good frame received
  input  wire logic                 ev_fcs_err,      // checksum error frame
  input  wire logic                 ev_align_err,    // alignment error frame
  input  wire logic                 byte_tick,       // one byte time on the link
  input  wire logic                 pause_rx,        // pause frame received
  input  wire logic [15:0]          pause_time,      // pause quanta carried
  input  wire logic                 tx_frame_req,    // system has a frame queued
  input  wire logic                 receive_enable,  // receiver on
  input  wire logic [PM_MODE_W-1:0] pattern_match_mode, // rx filter mode
  output logic                      tx_start_ok,     // frame may start now
  output logic                      tx_inhibit,      // mac control hold-off
  output logic                      tx_send_preamble,// backpressure preamble
  output logic      [15:0]          rx_pattern_checksum, // to rx filter only
  output logic      [15:0]          rx_pattern_offset,   // to rx filter only
  output logic                      pattern_write_unsafe,// write while rx busy
  output logic      [15:0]          mac_cfg1,        // config one to the mac
  output logic      [15:0]          mac_cfg2,        // config two to the mac
  output logic      [15:0]          mgmt_cfg,        // management config
  output logic      [15:0]          mgmt_cmd,        // management command
  output logic      [15:0]          mgmt_addr        // phy and reg address
);

  logic [REG_W-1:0]    regs    [NUM_REGS];
  logic [REG_W-1:0]    wr_val  [NUM_REGS];
  logic [NUM_REGS-1:0] hit;
  logic [NUM_REGS-1:0] wr_hit;
  logic [NUM_CNT-1:0]  cnt_inc;
  logic                size_ok;
  logic                low_half;
  logic                wr_go;
  logic                rd_go;
  logic [REG_W-1:0]    wdata16;
  logic [REG_W-1:0]    rd_sel;
  logic                any_hit;
  emr_alias_t          op;
  logic [31:0]         rdata_reg;
  logic                rvalid_reg;
  logic                backpressure_test;
  logic                forced_pause_test;
  logic                short_quantum_test;
  logic                pm_write;

  // byte accesses are dropped before any decode
  assign size_ok  = (reg_size == SIZE_HALF) || (reg_size == SIZE_WORD); // [RULE9]
  // an upper halfword access touches only unimplemented bits
  assign low_half = (reg_size == SIZE_WORD) || !reg_addr[1]; // [RULE10]
  assign wr_go    = reg_wr && size_ok && low_half;
  assign rd_go    = reg_rd && size_ok;
  assign wdata16  = reg_wdata[REG_W-1:0];
  assign op       = emr_alias_t'(reg_addr[3:2]); // [RULE8]
  assign cnt_inc  = {ev_align_err, ev_fcs_err, ev_rx_good,
                     ev_multi_col, ev_single_col, ev_tx_good};

  genvar i;
  generate
    for (i = 0; i < NUM_REGS; i++) begin : g_reg
      assign hit[i]    = reg_addr[ADDR_W-1:4] == REG_OFS[i][ADDR_W-1:4];
      assign wr_hit[i] = wr_go && hit[i];
      always_comb begin
        unique case (op)
          EMR_OP_WRITE: wr_val[i] = wdata16 & REG_MASK[i];
          EMR_OP_CLR:   wr_val[i] = regs[i] & ~wdata16;         // [RULE8]
          EMR_OP_SET:   wr_val[i] = (regs[i] | wdata16) & REG_MASK[i]; // [RULE8]
          EMR_OP_INV:   wr_val[i] = (regs[i] ^ wdata16) & REG_MASK[i]; // [RULE8]
        endcase
      end
      if (i < NUM_CNT) begin : g_cnt
        emr_stat_counter #(.W(REG_W)) u_cnt (
          .clk      (clk),
          .rst      (rst),
          .inc      (cnt_inc[i]),
          .load     (wr_hit[i]),
          .load_val (wr_val[i]),
          .count    (regs[i])
        ); // [RULE11]
      end else begin : g_plain
        logic [REG_W-1:0] val_reg;
        always_ff @(posedge clk or posedge rst) begin
          if (rst) begin
            val_reg <= REG_RST[i]; // [RULE7]
          end else if (wr_hit[i]) begin
            val_reg <= wr_val[i]; // [RULE10]
          end
        end
        assign regs[i] = val_reg;
      end
    end
  endgenerate

  assign any_hit = |hit;

  always_comb begin
    rd_sel = '0;
    for (int k = 0; k < NUM_REGS; k++) begin
      if (hit[k]) begin
        rd_sel = regs[k];
      end
    end
  end

  // unmapped addresses and the upper half read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg  <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= rd_go;
      if (rd_go) begin
        rdata_reg <= (any_hit && low_half) ? {16'h0000, rd_sel} : 32'h0000_0000; // [RULE10]
      end
    end
  end

  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  assign short_quantum_test = regs[IX_TEST][TEST_SHORT_QUANTUM_BIT];
  assign forced_pause_test  = regs[IX_TEST][TEST_FORCED_PAUSE_BIT];
  assign backpressure_test  = regs[IX_TEST][TEST_BACKPRESSURE_BIT];

  emr_pause_timer u_pause (
    .clk           (clk),
    .rst           (rst),
    .byte_tick     (byte_tick),
    .pause_rx      (pause_rx),
    .pause_time    (pause_time),
    .short_quantum (short_quantum_test), // [RULE3]
    .forced_pause  (forced_pause_test),  // [RULE2]
    .tx_inhibit    (tx_inhibit),
    .quanta_left   ()
  );

  // preamble only fills idle time, so a queued frame still goes out
  assign tx_start_ok      = tx_frame_req && !tx_inhibit; // [RULE2]
  assign tx_send_preamble = backpressure_test && !tx_start_ok; // [RULE1]

  // pattern values go only to the receive filter
  assign rx_pattern_checksum = regs[IX_PATTERN_CHECKSUM_FIELD]; // [RULE5] [RULE6]
  assign rx_pattern_offset   = regs[IX_PMO];  // [RULE5] [RULE7]
  // the filter relies on software, so an unsafe write is flagged, not blocked
  assign pm_write = wr_hit[IX_PATTERN_CHECKSUM_FIELD] || wr_hit[IX_PMO];
  assign pattern_write_unsafe = pm_write && receive_enable &&
                                (pattern_match_mode != '0); // [RULE4]

  assign mac_cfg1  = regs[IX_CFG1];
  assign mac_cfg2  = regs[IX_CFG2];
  assign mgmt_cfg  = regs[IX_MCFG];
  assign mgmt_cmd  = regs[IX_MCMD];
  assign mgmt_addr = regs[IX_MADR];

  initial begin
    if (PM_MODE_W < 1 || PM_MODE_W > 8) begin
      $error("emr_mac_regs: pattern mode width out of range");
    end
  end

  // checks
  sequence s_test_write(logic [15:0] v);
    wr_hit[IX_TEST] && wr_val[IX_TEST] == v;
  endsequence

  byte_ignored_a: assert property (@(posedge clk) disable iff (rst) // [RULE9]
    reg_wr && reg_size == SIZE_BYTE |=> $stable(regs[IX_TEST]) && $stable(regs[IX_PMO]))
    else $error("byte write changed a register");

  upper_zero_a: assert property (@(posedge clk) disable iff (rst) // [RULE10]
    rvalid_reg |-> reg_rdata[31:16] == 16'h0000)
    else $error("upper half of read data not zero");

  clr_alias_a: assert property (@(posedge clk) disable iff (rst) // [RULE8]
    wr_go && hit[IX_PMO] && op == EMR_OP_CLR
      |=> regs[IX_PMO] == ($past(regs[IX_PMO]) & ~$past(wdata16)))
    else $error("clear alias wrong");

  set_alias_a: assert property (@(posedge clk) disable iff (rst) // [RULE8]
    wr_go && hit[IX_PATTERN_CHECKSUM_FIELD] && op == EMR_OP_SET
      |=> regs[IX_PATTERN_CHECKSUM_FIELD] == ($past(regs[IX_PATTERN_CHECKSUM_FIELD]) | $past(wdata16)))
    else $error("set alias wrong");

  forced_hold_a: assert property (@(posedge clk) disable iff (rst) // [RULE2]
    s_test_write(16'h0002) |=> (!tx_start_ok && tx_inhibit)[*4])
    else $error("forced pause did not hold off transmit");

  bp_preamble_a: assert property (@(posedge clk) disable iff (rst) // [RULE1]
    backpressure_test && !tx_frame_req && !tx_inhibit |-> tx_send_preamble)
    else $error("backpressure did not send preamble");

  counter_inc_a: assert property (@(posedge clk) disable iff (rst) // [RULE11]
    ev_rx_good && !wr_hit[IX_RXOK] |=> regs[IX_RXOK] == $past(regs[IX_RXOK]) + 16'h0001)
    else $error("receive counter did not advance by one");

  short_quantum_a: assert property (@(posedge clk) disable iff (rst) // [RULE3]
    short_quantum_test && byte_tick && !pause_rx && u_pause.quanta_reg != 16'h0000
      |=> u_pause.quanta_reg == $past(u_pause.quanta_reg) - 16'h0001)
    else $error("short quantum did not count one byte time");

  mask_a: assert property (@(posedge clk) disable iff (rst) // [RULE10]
    (regs[IX_TEST] & ~REG_MASK[IX_TEST]) == 16'h0000)
    else $error("unimplemented test bits set");

endmodule : emr_mac_regs

// file: core/emr_pause_timer.sv
// emr_pause_timer: pause quanta countdown for the mac control sublayer.
// assumes byte_tick pulses once per transmitted byte time.
`timescale 1ns/1ps
module emr_pause_timer
  import emr_pkg::*;
(
  input  wire logic        clk,           // system clock
  input  wire logic        rst,           // async reset, active high
  input  wire logic        byte_tick,     // one byte time elapsed
  input  wire logic        pause_rx,      // pause control frame received
  input  wire logic [15:0] pause_time,    // its pause quanta
  input  wire logic        short_quantum, // quantum is one byte time
  input  wire logic        forced_pause,  // hold off as if paused
  output logic             tx_inhibit,    // transmission held off
  output logic      [15:0] quanta_left    // remaining quanta
);
  logic [15:0]       quanta_reg;
  logic [15:0]       quanta_next;
  logic [QCNT_W-1:0] sub_reg;
  logic [QCNT_W-1:0] sub_next;
  logic [QCNT_W-1:0] sub_last;
  logic              quantum_done;
  logic              running;

  assign sub_last     = short_quantum ? QUANTUM_LAST_SHORT : QUANTUM_LAST_NORMAL; // [RULE3]
  assign running      = quanta_reg != 16'h0000;
  assign quantum_done = byte_tick && running && (sub_reg >= sub_last);

  always_comb begin
    quanta_next = quanta_reg;
    sub_next    = sub_reg;
    if (pause_rx) begin
      quanta_next = pause_time;
      sub_next    = '0;
    end else if (quantum_done) begin
      quanta_next = quanta_reg - 16'h0001;
      sub_next    = '0;
    end else if (byte_tick && running) begin
      sub_next    = sub_reg + QCNT_W'(1);
    end
  end

  // forced pause drives tx_inhibit exactly like a running non-zero pause time
  assign tx_inhibit  = running || forced_pause; // [RULE2]
  assign quanta_left = quanta_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quanta_reg <= 16'h0000;
      sub_reg    <= '0;
    end else begin
      quanta_reg <= quanta_next;
      sub_reg    <= sub_next;
    end
  end
endmodule : emr_pause_timer

// file: core/emr_pkg.sv
// emr_pkg: register map, field positions, reset values and timing constants
// for the ethernet mac register block; shared by the top and the pause timer.
package emr_pkg;

  localparam int          NUM_REGS  = 19;
  localparam int          NUM_CNT   = 6;
  localparam int          REG_W     = 16;
  localparam int          ADDR_W    = 16;

  // access sizes on the register port
  localparam logic [1:0]  SIZE_BYTE = 2'h0;
  localparam logic [1:0]  SIZE_HALF = 2'h1;
  localparam logic [1:0]  SIZE_WORD = 2'h2;

  // alias selected by address bits 3:2
  typedef enum logic [1:0] {
    EMR_OP_WRITE = 2'b00,
    EMR_OP_CLR   = 2'b01,
    EMR_OP_SET   = 2'b10,
    EMR_OP_INV   = 2'b11
  } emr_alias_t;

  // register indices
  localparam int IX_TXOK  = 0;
  localparam int IX_SCOL  = 1;
  localparam int IX_MCOL  = 2;
  localparam int IX_RXOK  = 3;
  localparam int IX_FCS   = 4;
  localparam int IX_ALGN  = 5;
  localparam int IX_CFG1  = 6;
  localparam int IX_CFG2  = 7;
  localparam int IX_IPGT  = 8;
  localparam int IX_IFGR  = 9;
  localparam int IX_CLRT  = 10;
  localparam int IX_MAXF  = 11;
  localparam int IX_SUPP  = 12;
  localparam int IX_TEST  = 13;
  localparam int IX_MCFG  = 14;
  localparam int IX_MCMD  = 15;
  localparam int IX_MADR  = 16;
  localparam int IX_PATTERN_CHECKSUM_FIELD  = 17;
  localparam int IX_PMO   = 18;

  // byte offsets of each register base, low 16 bits of the address
  localparam logic [ADDR_W-1:0] REG_OFS [NUM_REGS] = '{
    16'h2110, 16'h2120, 16'h2130, 16'h2140, 16'h2150, 16'h2160,
    16'h2200, 16'h2210, 16'h2220, 16'h2230, 16'h2240, 16'h2250,
    16'h2260, 16'h2270, 16'h2280, 16'h2290, 16'h22A0, 16'h2300,
    16'h2310};

  // implemented bits; everything else reads zero and ignores writes
  localparam logic [REG_W-1:0] REG_MASK [NUM_REGS] = '{
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
    16'hCF1F, 16'h73FF, 16'h007F, 16'h7F7F, 16'h3F0F, 16'hFFFF,
    16'h1900, 16'h0007, 16'h803F, 16'h0003, 16'h1F1F, 16'hFFFF,
    16'hFFFF};

  localparam logic [REG_W-1:0] REG_RST [NUM_REGS] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h800D, 16'h4082, 16'h0012, 16'h0C12, 16'h370F, 16'h05EE,
    16'h1000, 16'h0000, 16'h0020, 16'h0000, 16'h0100, 16'h0000,
    16'h0000};

  // test register fields
  localparam int TEST_SHORT_QUANTUM_BIT = 0;
  localparam int TEST_FORCED_PAUSE_BIT  = 1;
  localparam int TEST_BACKPRESSURE_BIT  = 2;

  // pause quantum length in byte times
  localparam int          QUANTUM_BYTES_NORMAL = 64;
  localparam int          QUANTUM_BYTES_SHORT  = 1;
  localparam int          QCNT_W               = 6;
  localparam logic [QCNT_W-1:0] QUANTUM_LAST_NORMAL =
    QCNT_W'(QUANTUM_BYTES_NORMAL - 1);
  localparam logic [QCNT_W-1:0] QUANTUM_LAST_SHORT =
    QCNT_W'(QUANTUM_BYTES_SHORT - 1);

endpackage : emr_pkg

// file: core/emr_stat_counter.sv
// emr_stat_counter: one frame statistics counter, software loadable.
// assumes inc is a one-cycle pulse per frame of the counted class.
`timescale 1ns/1ps
module emr_stat_counter #(
  parameter int W = 16
) (
  input  wire logic         clk,      // system clock
  input  wire logic         rst,      // async reset, active high
  input  wire logic         inc,      // one frame of this class seen
  input  wire logic         load,     // software write to the counter
  input  wire logic [W-1:0] load_val, // value after the alias operation
  output logic      [W-1:0] count     // current count
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic [W-1:0] base;

  // a frame landing in the write cycle still counts on top of the new value
  assign base       = load ? load_val : count_reg;
  assign count_next = base + W'(inc); // [RULE11]
  assign count      = count_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  initial begin
    if (W < 1) begin
      $error("emr_stat_counter: width must be positive");
    end
  end
endmodule : emr_stat_counter

// file: tb/emr_phy_model.sv
// emr_phy_model: far side of the mac as the register block sees it:
// byte times, one pulse per finished frame, received pause frames.
// assumes the bench raises a request for one cycle, just after an edge.
`timescale 1ns/1ps
module emr_phy_model (
  input  wire logic        clk,        // system clock
  input  wire logic        rst,        // async reset, active high
  input  wire logic [5:0]  frame_req,  // one-hot class of a finished frame
  input  wire logic        pause_req,  // deliver a pause frame
  input  wire logic [15:0] pause_val,  // its pause quanta
  output logic      [5:0]  frame_ev,   // one pulse per frame
  output logic             byte_tick,  // one byte time every four clocks
  output logic             pause_rx,   // pause frame arrived
  output logic      [15:0] pause_time  // quanta, junk outside pause_rx
);
  logic [1:0] div_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg    <= 2'h0;
      frame_ev   <= 6'h00;
      pause_rx   <= 1'b0;
      pause_time <= 16'h0000;
    end else begin
      div_reg    <= div_reg + 2'h1;
      frame_ev   <= frame_req;
      pause_rx   <= pause_req;
      // stale quanta are not held, so a late sample shows up as a fault
      pause_time <= pause_req ? pause_val : ~pause_time;
    end
  end
  assign byte_tick = (div_reg == 2'h3);
endmodule : emr_phy_model

// file: tb/tb_top.sv
// tb_top: self-checking bench for the mac register block and its phy side.
// assumes emr_pkg and the design files are compiled before this file.
`timescale 1ns/1ps
module tb_top;
  import emr_pkg::*;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [1:0]        reg_size = SIZE_WORD;
  logic [31:0]       reg_wdata = '0;
  logic [31:0]       reg_rdata;
  logic              reg_rvalid;
  logic              tx_frame_req = 1'b0;
  logic              receive_enable = 1'b0;
  logic [3:0]        pattern_match_mode = 4'h0;
  logic [5:0]        frame_req = 6'h0;
  logic [5:0]        frame_ev;
  logic              pause_req = 1'b0;
  logic [15:0]       pause_val = 16'h0;
  logic [15:0]       pause_time, rx_cs, rx_ofs, cfg1, cfg2, mcfg, mcmd, madr;
  logic              byte_tick, pause_rx, tx_ok, tx_inh, tx_pre, unsafe, unsafe_seen;
  logic [15:0]       sh [NUM_REGS];
  logic [31:0]       expq [$];
  int                error_cnt = 0;
  int                comparisons = 0;

  always #25 clk = ~clk;

  emr_mac_regs i_emr_mac_regs (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_size(reg_size), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ev_tx_good(frame_ev[0]),
    .ev_single_col(frame_ev[1]), .ev_multi_col(frame_ev[2]), .ev_rx_good(frame_ev[3]),
    .ev_fcs_err(frame_ev[4]), .ev_align_err(frame_ev[5]), .byte_tick(byte_tick),
    .pause_rx(pause_rx), .pause_time(pause_time), .tx_frame_req(tx_frame_req),
    .receive_enable(receive_enable), .pattern_match_mode(pattern_match_mode),
    .tx_start_ok(tx_ok), .tx_inhibit(tx_inh), .tx_send_preamble(tx_pre),
    .rx_pattern_checksum(rx_cs), .rx_pattern_offset(rx_ofs),
    .pattern_write_unsafe(unsafe), .mac_cfg1(cfg1), .mac_cfg2(cfg2),
    .mgmt_cfg(mcfg), .mgmt_cmd(mcmd), .mgmt_addr(madr));

  emr_phy_model i_emr_phy_model (.clk(clk), .rst(rst), .frame_req(frame_req),
    .pause_req(pause_req), .pause_val(pause_val), .frame_ev(frame_ev),
    .byte_tick(byte_tick), .pause_rx(pause_rx), .pause_time(pause_time));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic endt(input string name);
    $display("test %s done", name);
  endtask : endt

  // byte and odd sizes push nothing: any rvalid they cause is unexpected
  task automatic rd(input logic [15:0] a, input logic [1:0] sz, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    reg_size <= sz;
    if (sz == SIZE_HALF || sz == SIZE_WORD) expq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] sz);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_size  <= sz;
    #1 unsafe_seen = unsafe;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic acc(input int ix, input logic [1:0] op, input logic [31:0] d);
    logic [15:0] m;
    m = REG_MASK[ix] & d[15:0];
    wr(REG_OFS[ix] + {12'h0, op, 2'h0}, d, SIZE_WORD);
    case (op)
      EMR_OP_WRITE: sh[ix] = (sh[ix] & ~REG_MASK[ix]) | m;
      EMR_OP_CLR:   sh[ix] = sh[ix] & ~m;
      EMR_OP_SET:   sh[ix] = sh[ix] | m;
      default:      sh[ix] = sh[ix] ^ m;
    endcase
  endtask : acc

  always @(posedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (expq.size() == 0) check(reg_rdata, 32'hFFFFFFFF);
      else check(reg_rdata, expq.pop_front());
    end
  end

  // a pause of q quanta holds transmit off for exactly q*len byte ticks
  task automatic pq(input logic sq, input logic [15:0] q);
    int n;
    int tot;
    n   = 0;
    tot = q * (sq ? QUANTUM_BYTES_SHORT : QUANTUM_BYTES_NORMAL);
    acc(IX_TEST, EMR_OP_WRITE, {31'h0, sq});
    @(posedge clk);
    pause_val <= q;
    pause_req <= 1'b1;
    @(posedge clk);
    pause_req <= 1'b0;
    do @(posedge clk); while (pause_rx !== 1'b1);
    #1 check(tx_inh, tot != 0);
    while (n < tot) begin
      @(posedge clk);
      if (byte_tick === 1'b1) n++;
      #1 check(tx_inh, n < tot);
    end
  endtask : pq

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial begin
    logic [15:0] rnd;
    void'($urandom(13669));
    foreach (sh[i]) sh[i] = REG_RST[i];
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      rd(REG_OFS[i], SIZE_WORD, {16'h0, REG_RST[i]});
      rd(REG_OFS[i] + 16'h2, SIZE_HALF, 32'h0);
    end
    rd(16'h2400, SIZE_WORD, 32'h0);
    rd(REG_OFS[IX_TEST], SIZE_BYTE, 32'h0);
    endt("reset");
    for (int i = 0; i < NUM_REGS; i++) begin
      for (int op = 0; op < 4; op++) begin
        acc(i, 2'(op), $urandom());
        rd(REG_OFS[i], SIZE_WORD, {16'h0, sh[i]});
      end
    end
    check({cfg1, cfg2}, {sh[IX_CFG1], sh[IX_CFG2]});
    check({16'h0, mcfg}, {16'h0, sh[IX_MCFG]});
    check({mcmd, madr}, {sh[IX_MCMD], sh[IX_MADR]});
    check({16'h0, rx_ofs}, {16'h0, sh[IX_PMO]});
    endt("alias");
    wr(REG_OFS[IX_PMO], 32'h0000A5A5, SIZE_BYTE);
    wr(REG_OFS[IX_PMO] + 16'h2, 32'h5A5A5A5A, SIZE_HALF);
    wr(REG_OFS[IX_PMO], 32'h00001234, 2'h3);
    rd(REG_OFS[IX_PMO], SIZE_WORD, {16'h0, sh[IX_PMO]});
    wr(REG_OFS[IX_PMO], 32'hFFFFC3A1, SIZE_HALF);
    wr(REG_OFS[IX_PMO] + 16'h8, 32'h00000004, SIZE_HALF);
    rd(REG_OFS[IX_PMO], SIZE_WORD, 32'h0000C3A5);
    endt("sizes");
    acc(IX_TEST, EMR_OP_WRITE, 32'h0);
    tx_frame_req <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      receive_enable     <= (c != 2);
      pattern_match_mode <= (c == 1) ? 4'h0 : 4'h3;
      rnd = 16'($urandom());
      acc(IX_PATTERN_CHECKSUM_FIELD, EMR_OP_WRITE, {16'hFFFF, rnd});
      #1 check(unsafe_seen, c == 0);
      check({16'h0, rx_cs}, {16'h0, rnd[15:8], rnd[7:0]});
      check(tx_ok, 1'b1);
      rd(REG_OFS[IX_PATTERN_CHECKSUM_FIELD], SIZE_WORD, {16'h0, rnd});
    end
    endt("pattern");
    acc(IX_TEST, EMR_OP_WRITE, 32'h2);
    #1 check({tx_inh, tx_ok, tx_pre}, 3'b100);
    acc(IX_TEST, EMR_OP_SET, 32'h4);
    #1 check({tx_inh, tx_ok, tx_pre}, 3'b101);
    acc(IX_TEST, EMR_OP_CLR, 32'h2);
    #1 check({tx_inh, tx_ok, tx_pre}, 3'b010);
    @(posedge clk);
    tx_frame_req <= 1'b0;
    #1 check({tx_ok, tx_pre}, 2'b01);
    endt("test bits");
    pq(1'b0, 16'h0001);
    pq(1'b1, 16'h0003);
    pq(1'b1, 16'h0000);
    endt("pause");
    for (int k = 0; k < NUM_CNT; k++) begin
      @(posedge clk);
      frame_req <= 6'(1 << k);
      @(posedge clk);
      frame_req <= 6'h0;
      repeat (3) @(posedge clk);
      sh[k] = sh[k] + 16'h1;
      rd(REG_OFS[k], SIZE_WORD, {16'h0, sh[k]});
    end
    endt("counters");
    repeat (4) @(posedge clk);
    check(expq.size(), 32'h0);
    results();
  end
endmodule : tb_top
